// ==== testbench/fpr_flash_model.sv ====
// Behavioural flash device answering its reset pin on ready/busy
`timescale 1ns/1ps
module fpr_flash_model
#(
    parameter int COLD = 24,
    parameter int WARM = 6
)
(
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      ready_busy_n
);
    logic [1:0] st  = 2'h0; // Power-on, hardware reset, standby
    int         cnt = COLD;
    logic       cold_done = 1'h0;
    assign ready_busy_n = (cnt == 0); // Busy only while a load count runs; ready while reset is held low after it
    always @(posedge clk)
        if (cnt > 0)
            cnt <= cnt - 1; // Pins ignored while loading
        else if (st == 2'h2 && !reset_n)
        begin
            // Warm reset only once power-on has finished
            st  <= cold_done ? 2'h1 : 2'h0;
            cnt <= cold_done ? WARM : COLD; // Reload WARM after power-on, else COLD
        end
        else if (st == 2'h0 || reset_n)
        begin
            st        <= reset_n ? 2'h2 : 2'h1;
            cold_done <= 1'h1;
        end
endmodule

// ==== testbench/fpr_host_asserts.sv ====
// Checker of the flash reset host port timing
`timescale 1ns/1ps
module fpr_host_asserts
#(
    parameter int unsigned SUPPLY_SETUP_CYC = 20,
    parameter int unsigned RESET_LOW_CYC    = 5
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_ARST_N,
    input wire logic I_RESET_REQ,
    input wire logic I_ACCESS_REQ,
    input wire logic I_ACCESS_DONE,
    input wire logic I_READY_BUSY_N,
    input wire logic O_RESET_N,
    input wire logic O_SELECT_N,
    input wire logic O_ACCESS_GRANT,
    input wire logic O_DEVICE_READY,
    input wire logic O_DEVICE_BUSY
);
    int unsigned lo;
    logic        up;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);
    // Cycles with reset pin low, and first release seen
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            lo <= '0;
            up <= 1'h0;
        end
        else
        begin
            lo <= O_RESET_N ? '0 : lo + 1;
            up <= up | O_RESET_N;
        end
    end
    sequence s_gap; O_SELECT_N && !O_ACCESS_GRANT ##1 O_DEVICE_READY;
    endsequence
    property p_low; $rose(O_RESET_N) |->
        lo >= (up ? RESET_LOW_CYC : SUPPLY_SETUP_CYC + RESET_LOW_CYC);
    endproperty
    a_low: assert property (p_low)
        else $error("reset low too short");
    property p_first; !O_SELECT_N |-> up && O_RESET_N; endproperty
    a_first: assert property (p_first)
        else $error("early select");
    property p_rh; $fell(O_SELECT_N) |-> $past(O_RESET_N, 2); endproperty
    a_rh: assert property (p_rh)
        else $error("reset high too short");
    property p_ceh; $rose(O_SELECT_N) |=> O_SELECT_N; endproperty
    a_ceh: assert property (p_ceh)
        else $error("select gap short");
    property p_grant; O_DEVICE_READY && I_ACCESS_REQ && !I_RESET_REQ
        |=> !O_SELECT_N && O_ACCESS_GRANT; endproperty
    a_grant: assert property (p_grant)
        else $error("no grant");
    property p_done; O_ACCESS_GRANT && I_ACCESS_DONE && !I_RESET_REQ
        |=> s_gap; endproperty
    a_done: assert property (p_done)
        else $error("bad end");
    property p_pulse; O_DEVICE_READY && I_RESET_REQ |=> !O_RESET_N [*2];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("short pulse");
    property p_busy; !I_READY_BUSY_N [*5] |-> O_DEVICE_BUSY; endproperty
    a_busy: assert property (p_busy)
        else $error("busy lost");
endmodule
bind fpr_host fpr_host_asserts #(.SUPPLY_SETUP_CYC(SUPPLY_SETUP_CYC),
    .RESET_LOW_CYC(RESET_LOW_CYC)) u_asserts (.*);

// ==== testbench/test_fpr_host.sv ====
// Self-checking bench for the flash reset host
`timescale 1ns/1ps
module test_fpr_host;
    typedef struct {int hold; logic by_rst; logic exp_rst;} fpr_row_t;
    fpr_row_t rows [3] = '{'{0, 1'h0, 1'h1}, '{3, 1'h0, 1'h1},
                           '{1, 1'h1, 1'h0}};
    logic clk = 1'h0, arst_n = 1'h0, rreq = 1'h0, areq = 1'h0, adone = 1'h0;
    logic rb_n, rst_n, sel_n, grant, rdy, busy;
    int   mismatches = 0, total_checks = 0, cyc = 0;
    always #50 clk = ~clk;
    fpr_host #(.SUPPLY_SETUP_CYC(20), .RESET_LOW_CYC(5)) u_dut (
        .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_RESET_REQ(rreq),
        .I_ACCESS_REQ(areq), .I_ACCESS_DONE(adone), .I_READY_BUSY_N(rb_n),
        .O_RESET_N(rst_n), .O_SELECT_N(sel_n), .O_ACCESS_GRANT(grant),
        .O_DEVICE_READY(rdy), .O_DEVICE_BUSY(busy));
    fpr_flash_model u_flash (.clk(clk), .reset_n(rst_n), .ready_busy_n(rb_n));
    task automatic complete_run();
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [3:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wait_rdy();
        repeat (60) if (rdy !== 1'h1) @(negedge clk);
        check("ready", rdy, 1'h1);
    endtask
    task automatic access(input int hold, input logic by_rst, exp_rst);
        wait_rdy();
        areq = 1'h1;
        @(negedge clk);
        areq = 1'h0;
        check("grant", {grant, sel_n}, 2'h2);
        repeat (hold) @(negedge clk);
        check("held", sel_n, 1'h0);
        adone = !by_rst;
        rreq = by_rst;
        @(negedge clk);
        adone = 1'h0;
        check("gap", {grant, sel_n}, 2'h1);
        repeat (4) @(negedge clk);
        check("rst_pin", rst_n, exp_rst);
        rreq = 1'h0;
    endtask
    always @(posedge clk)
        if (++cyc > 3000)
        begin
            mismatches++;
            complete_run();
        end
    initial
    begin
        repeat (8) @(negedge clk);
        check("rst_arst", {rst_n, sel_n, rdy, busy}, 4'h5);
        arst_n = 1'h1;
        repeat (20) @(negedge clk);
        check("rst_setup", {rst_n, sel_n}, 2'h1);
        wait_rdy();
        foreach (rows[i])
            access(rows[i].hold, rows[i].by_rst, rows[i].exp_rst);
        wait_rdy();
        rreq = 1'h1;
        areq = 1'h1;
        repeat (12) @(negedge clk);
        check("long_rst", {rst_n, sel_n, busy}, 3'h2);
        rreq = 1'h0;
        areq = 1'h0;
        repeat (2) @(negedge clk);
        check("rst_rel", rst_n, 1'h1);
        wait_rdy();
        arst_n = 1'h0;
        @(negedge clk);
        check("rst_mid", {rst_n, sel_n, rdy, busy}, 4'h5);
        arst_n = 1'h1;
        repeat (20) @(negedge clk);
        check("rst_again", rst_n, 1'h0);
        wait_rdy();
        complete_run();
    end
endmodule

// ==== verilog/fpr_host.sv ====
// Host controller sequencing flash power-up, reset and chip select
//
// Contract
// - Select falls only after supply setup time
// - Reset pulse at least 200 ns, 35 us
// - Reset-to-select measured from setup end
// - Reset high 50 ns before select low
// - Reset low time alone covers 35 us
// - Select stays high 20 ns between accesses
`timescale 1ns/1ps
module fpr_host
#(
    parameter int unsigned SUPPLY_SETUP_CYC = fpr_pkg::SUPPLY_SETUP_CYC,
    parameter int unsigned RESET_LOW_CYC    =
        fpr_pkg::RESET_LOW_TO_SELECT_CYC
)
(
    input  wire logic I_CORE_CLK,
    input  wire logic I_ARST_N,
    input  wire logic I_RESET_REQ,
    input  wire logic I_ACCESS_REQ,
    input  wire logic I_ACCESS_DONE,
    input  wire logic I_READY_BUSY_N,
    output logic      O_RESET_N,
    output logic      O_SELECT_N,
    output logic      O_ACCESS_GRANT,
    output logic      O_DEVICE_READY,
    output logic      O_DEVICE_BUSY
);
    fpr_pkg::fpr_state_t        state;
    fpr_pkg::fpr_state_t        next_state;
    logic [fpr_pkg::CNT_W-1:0]  cnt;
    logic [fpr_pkg::CNT_W-1:0]  next_cnt;
    logic [fpr_pkg::CNT_W-1:0]  low_cnt;
    logic [fpr_pkg::CNT_W-1:0]  next_low_cnt;
    logic                       reset_n;
    logic                       next_reset_n;
    logic                       select_n;
    logic                       next_select_n;
    logic [2:0]                 rb_sync;
    logic [2:0]                 next_rb_sync;
    logic                       rb_stable;
    logic                       next_rb_stable;

    // Counter limits in clock cycles
    localparam logic [fpr_pkg::CNT_W-1:0] SETUP_END =
        fpr_pkg::CNT_W'(SUPPLY_SETUP_CYC - 1);
    localparam logic [fpr_pkg::CNT_W-1:0] LOW_END =
        fpr_pkg::CNT_W'(RESET_LOW_CYC);
    localparam logic [fpr_pkg::CNT_W-1:0] PULSE_END =
        fpr_pkg::CNT_W'(fpr_pkg::RESET_PULSE_CYC);
    localparam logic [fpr_pkg::CNT_W-1:0] HIGH_END =
        fpr_pkg::CNT_W'(fpr_pkg::RESET_HIGH_CYC - 1);
    localparam logic [fpr_pkg::CNT_W-1:0] GAP_END =
        fpr_pkg::CNT_W'(fpr_pkg::SELECT_HIGH_CYC - 1);
    localparam logic [fpr_pkg::CNT_W-1:0] CNT_ONE =
        fpr_pkg::CNT_W'(1);
    localparam logic [fpr_pkg::CNT_W-1:0] CNT_MAX = '1;

    // Ready/busy pin synchroniser, change taken when stages 2 and 3 agree
    always_comb
    begin
        next_rb_sync   = {rb_sync[1:0], I_READY_BUSY_N};
        next_rb_stable = rb_stable;
        if (rb_sync[1] == rb_sync[2])
        begin
            next_rb_stable = rb_sync[2];
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rb_sync   <= 3'h0;
            rb_stable <= 1'h0;
        end
        else
        begin
            rb_sync   <= next_rb_sync;
            rb_stable <= next_rb_stable;
        end
    end

    // Pin sequencer: power-up hold, reset pulse, release, select
    always_comb
    begin
        next_state    = state;
        next_cnt      = cnt + CNT_ONE;
        next_low_cnt  = low_cnt;
        next_reset_n  = reset_n;
        next_select_n = 1'h1;
        unique case (state)
            fpr_pkg::ST_POWER_UP:
            begin
                // Reset held low through supply setup; select kept high
                next_reset_n = 1'h0;
                if (cnt >= SETUP_END)
                begin
                    // Low time counted again from setup end
                    next_state   = fpr_pkg::ST_WAIT_LOW;
                    next_low_cnt = '0;
                    next_cnt     = '0;
                end
            end
            fpr_pkg::ST_PULSE:
            begin
                next_reset_n = 1'h0;
                next_low_cnt = low_cnt + CNT_ONE;
                if (cnt >= PULSE_END - CNT_ONE)
                begin
                    next_state = fpr_pkg::ST_WAIT_LOW;
                end
            end
            fpr_pkg::ST_WAIT_LOW:
            begin
                // Saturate so a long held request never wraps the count
                if (low_cnt != CNT_MAX)
                begin
                    next_low_cnt = low_cnt + CNT_ONE;
                end
                next_reset_n = 1'h0;
                if (low_cnt >= LOW_END - CNT_ONE && !I_RESET_REQ)
                begin
                    // Low time alone covers the low-to-select; high time follows
                    next_state   = fpr_pkg::ST_WAIT_HIGH;
                    next_reset_n = 1'h1;
                    next_cnt     = '0;
                end
            end
            fpr_pkg::ST_WAIT_HIGH:
            begin
                if (cnt >= HIGH_END && rb_stable)
                begin
                    next_state = fpr_pkg::ST_READY;
                end
            end
            fpr_pkg::ST_READY:
            begin
                if (I_RESET_REQ)
                begin
                    // Any later reset; device picks warm or cold itself
                    next_state   = fpr_pkg::ST_PULSE;
                    next_reset_n = 1'h0;
                    next_cnt     = '0;
                    next_low_cnt = '0;
                end
                else if (I_ACCESS_REQ)
                begin
                    next_state    = fpr_pkg::ST_ACCESS;
                    next_select_n = 1'h0;
                end
            end
            fpr_pkg::ST_ACCESS:
            begin
                // Select held low until done or a reset request
                next_select_n = 1'h0;
                if (I_ACCESS_DONE || I_RESET_REQ)
                begin
                    next_state    = fpr_pkg::ST_SELECT_GAP;
                    next_select_n = 1'h1;
                    next_cnt      = '0;
                end
            end
            fpr_pkg::ST_SELECT_GAP:
            begin
                if (cnt >= GAP_END)
                begin
                    next_state = fpr_pkg::ST_READY;
                end
            end
            default:
            begin
                // Unused code: restart the power-up hold
                next_state    = fpr_pkg::ST_POWER_UP;
                next_reset_n  = 1'h0;
                next_cnt      = '0;
                next_low_cnt  = '0;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            state    <= fpr_pkg::ST_POWER_UP;
            cnt      <= '0;
            low_cnt  <= '0;
            reset_n  <= 1'h0;
            select_n <= 1'h1;
        end
        else
        begin
            state    <= next_state;
            cnt      <= next_cnt;
            low_cnt  <= next_low_cnt;
            reset_n  <= next_reset_n;
            select_n <= next_select_n;
        end
    end

    // Registered pin drives and decoded handshake outputs
    assign O_RESET_N      = reset_n;
    assign O_SELECT_N     = select_n;
    assign O_ACCESS_GRANT = (state == fpr_pkg::ST_ACCESS);
    assign O_DEVICE_READY = (state == fpr_pkg::ST_READY);
    assign O_DEVICE_BUSY  = !rb_stable;
endmodule

// ==== verilog/fpr_pkg.sv ====
// Package with timing constants and states for the flash reset host
package fpr_pkg;
    localparam int unsigned CLK_PERIOD_NS            = 100;
    localparam int unsigned CORE_SUPPLY_SETUP_US     = 300;
    localparam int unsigned IO_SUPPLY_SETUP_US       = 300;
    localparam int unsigned RESET_LOW_TO_SELECT_US   = 35;
    localparam int unsigned RESET_PULSE_WIDTH_NS     = 200;
    localparam int unsigned RESET_HIGH_TO_SELECT_NS  = 50;
    localparam int unsigned SELECT_HIGH_PULSE_NS     = 20;

    // Least times round up to whole cycles; pulse, high and gap times at least one
    localparam int unsigned SUPPLY_SETUP_US =
        (CORE_SUPPLY_SETUP_US > IO_SUPPLY_SETUP_US) ?
        CORE_SUPPLY_SETUP_US : IO_SUPPLY_SETUP_US;
    localparam int unsigned SUPPLY_SETUP_CYC =
        (SUPPLY_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_LOW_TO_SELECT_CYC =
        (RESET_LOW_TO_SELECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RP_RAW =
        (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_PULSE_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
    localparam int unsigned RH_RAW =
        (RESET_HIGH_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_HIGH_CYC = (RH_RAW < 1) ? 1 : RH_RAW;
    localparam int unsigned CEH_RAW =
        (SELECT_HIGH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SELECT_HIGH_CYC = (CEH_RAW < 1) ? 1 : CEH_RAW;

    localparam int CNT_W = 16;

    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_PULSE,
        ST_WAIT_LOW,
        ST_WAIT_HIGH,
        ST_READY,
        ST_ACCESS,
        ST_SELECT_GAP
    } fpr_state_t;
endpackage
